// *** logic/flash_erase_ctrl.v ***
// Host controller that issues erase, suspend and resume sequences to a x16 NOR flash.
// How it works
// - Sector erase is six writes ending with 50H at the sector address.
// - Block erase is six writes ending with 30H at the block address.
// - Boot-protect output is held steady during every command sequence.
// - Suspend is one write of B0H; reads may follow as soon as that write ends, with no waiting time.
// - Resume is one write of 30H at any address.
// - Chip erase is six writes ending with 10H at address 555H.
// - Status polls use the address inside the operation's target region.
// - A finished status is read once more; if that reread disagrees, failure is declared.
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_ctrl_defs.vh"
module flash_erase_ctrl #(
    parameter STROBE_CYC = `FEC_STROBE_CYC
) (
    input wire mclk_i,
    input wire rst_n_i,
    input wire psel_i,
    input wire penable_i,
    input wire pwrite_i,
    input wire [11:0] paddr_i,
    input wire [31:0] pwdata_i,
    output wire [31:0] prdata_o,
    output wire pready_o,
    output wire pslverr_o,
    output reg [19:0] flash_addr_o,
    output reg [15:0] flash_dq_o,
    output reg flash_dq_oe_o,
    input wire [15:0] flash_dq_i,
    output reg flash_ce_n_o,
    output reg flash_we_n_o,
    output reg flash_oe_n_o,
    output reg boot_protect_n_o,
    input wire ready_busy_n_i
);
    localparam ST_IDLE = 3'h0;
    localparam ST_SETUP = 3'h1;
    localparam ST_LOW = 3'h2;
    localparam ST_HIGH = 3'h3;
    localparam ST_RD = 3'h4;
    localparam ST_RDGAP = 3'h5;
    localparam [1:0] REREAD_LAST = 2'd`FEC_REREADS - 2'd1;

    reg [2:0] state_reg;
    reg [2:0] cmd_reg;
    reg [2:0] step_reg;
    reg [2:0] nsteps_reg;
    reg [7:0] cnt_reg;
    reg [19:0] target_reg;
    reg [15:0] rdata_reg;
    reg [15:0] prev_reg;
    reg [1:0] rd_idx_reg;
    reg wp_cfg_reg;
    reg suspended_reg;
    reg done_reg;
    reg fail_reg;
    reg poll_toggle_reg;
    reg [1:0] reread_reg;
    reg [19:0] wr_addr;
    reg [15:0] wr_data;
    reg [31:0] rd_mux;

    wire bus_wr = psel_i & penable_i & pwrite_i;
    wire one_shot = pwdata_i[2:0] == `FEC_CMD_SUSPEND || pwdata_i[2:0] == `FEC_CMD_RESUME;
    wire busy_flash = ~ready_busy_n_i;
    wire poll_cmd = pwdata_i[2:0] == `FEC_CMD_POLL;
    wire resume_ok = pwdata_i[2:0] == `FEC_CMD_RESUME && suspended_reg;
    wire suspend_ok = pwdata_i[2:0] == `FEC_CMD_SUSPEND && busy_flash && !suspended_reg;
    wire idle_ok = !busy_flash && !suspended_reg;
    wire start_ok = state_reg == ST_IDLE && ((idle_ok && !one_shot) || suspend_ok || resume_ok
        || poll_cmd || (suspended_reg && pwdata_i[2:0] == `FEC_CMD_READ));
    wire ctrl_wr = bus_wr && paddr_i == `FEC_OFF_CTRL;
    wire [15:0] cur = rd_idx_reg == 2'h0 ? prev_reg : flash_dq_i;

    assign pready_o = 1'b1;
    assign pslverr_o = 1'b0;
    assign prdata_o = rd_mux;

    always @* begin
        rd_mux = 32'h0;
        if (paddr_i == `FEC_OFF_CTRL) begin
            rd_mux = {28'h0, wp_cfg_reg, cmd_reg};
        end else if (paddr_i == `FEC_OFF_ADDR) begin
            rd_mux = {12'h0, target_reg};
        end else if (paddr_i == `FEC_OFF_STATUS) begin
            rd_mux = {24'h0, poll_toggle_reg, reread_reg, fail_reg, done_reg, suspended_reg,
                busy_flash, state_reg != ST_IDLE};
        end else if (paddr_i == `FEC_OFF_RDATA) begin
            rd_mux = {16'h0, rdata_reg};
        end
    end

    always @* begin
        wr_addr = target_reg;
        wr_data = 16'h0;
        case (step_reg)
            3'h0: begin
                wr_addr = `FEC_ADDR_UNLOCK1;
                wr_data = `FEC_CODE_UNLOCK1;
            end
            3'h1: begin
                wr_addr = `FEC_ADDR_UNLOCK2;
                wr_data = `FEC_CODE_UNLOCK2;
            end
            3'h2: begin
                wr_addr = `FEC_ADDR_UNLOCK1;
                wr_data = `FEC_CODE_SETUP;
            end
            3'h3: begin
                wr_addr = `FEC_ADDR_UNLOCK1;
                wr_data = `FEC_CODE_UNLOCK1;
            end
            3'h4: begin
                wr_addr = `FEC_ADDR_UNLOCK2;
                wr_data = `FEC_CODE_UNLOCK2;
            end
            default: begin
                wr_addr = target_reg;
                wr_data = `FEC_CODE_BLOCK;
            end
        endcase
        if (step_reg == 3'h5 || nsteps_reg == 3'h1) begin
            if (cmd_reg == `FEC_CMD_SECTOR) begin
                wr_data = `FEC_CODE_SECTOR;
            end else if (cmd_reg == `FEC_CMD_CHIP) begin
                wr_addr = `FEC_ADDR_UNLOCK1;
                wr_data = `FEC_CODE_CHIP;
            end else if (cmd_reg == `FEC_CMD_SUSPEND) begin
                wr_data = `FEC_CODE_SUSPEND;
            end else if (cmd_reg == `FEC_CMD_RESUME) begin
                wr_data = `FEC_CODE_RESUME;
            end
        end
    end

    always @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state_reg <= ST_IDLE;
            cmd_reg <= 3'h0;
            step_reg <= 3'h0;
            nsteps_reg <= 3'h0;
            cnt_reg <= 8'h0;
            target_reg <= 20'h0;
            rdata_reg <= 16'h0;
            prev_reg <= 16'h0;
            rd_idx_reg <= 2'h0;
            wp_cfg_reg <= 1'b1;
            suspended_reg <= 1'b0;
            done_reg <= 1'b0;
            fail_reg <= 1'b0;
            poll_toggle_reg <= 1'b0;
            reread_reg <= 2'h0;
            flash_addr_o <= 20'h0;
            flash_dq_o <= 16'h0;
            flash_dq_oe_o <= 1'b0;
            flash_ce_n_o <= 1'b1;
            flash_we_n_o <= 1'b1;
            flash_oe_n_o <= 1'b1;
            boot_protect_n_o <= 1'b1;
        end else begin
            if (bus_wr && paddr_i == `FEC_OFF_ADDR && state_reg == ST_IDLE) begin
                target_reg <= pwdata_i[19:0];
            end
            if (ctrl_wr && state_reg == ST_IDLE) begin
                wp_cfg_reg <= pwdata_i[3];
                boot_protect_n_o <= pwdata_i[3];
            end
            if (ctrl_wr && start_ok) begin
                cmd_reg <= pwdata_i[2:0];
                step_reg <= 3'h0;
                done_reg <= 1'b0;
                fail_reg <= 1'b0;
                cnt_reg <= 8'h0;
                if (pwdata_i[2:0] == `FEC_CMD_READ || poll_cmd) begin
                    nsteps_reg <= 3'h0;
                    flash_addr_o <= target_reg;
                    rd_idx_reg <= 2'h0;
                    reread_reg <= 2'h0;
                    state_reg <= ST_RD;
                end else if (pwdata_i[2:0] == `FEC_CMD_SUSPEND || resume_ok) begin
                    nsteps_reg <= 3'h1;
                    step_reg <= 3'h5;
                    state_reg <= ST_SETUP;
                end else if (pwdata_i[2:0] != 3'h0) begin
                    nsteps_reg <= 3'h6;
                    state_reg <= ST_SETUP;
                end
            end
            case (state_reg)
                ST_SETUP: begin
                    flash_addr_o <= wr_addr;
                    flash_dq_o <= wr_data;
                    flash_dq_oe_o <= 1'b1;
                    flash_oe_n_o <= 1'b1;
                    flash_ce_n_o <= 1'b0;
                    cnt_reg <= 8'h0;
                    state_reg <= ST_LOW;
                end
                ST_LOW: begin
                    flash_we_n_o <= 1'b0;
                    cnt_reg <= cnt_reg + 8'h1;
                    if (cnt_reg == STROBE_CYC[7:0]) begin
                        flash_we_n_o <= 1'b1;
                        cnt_reg <= 8'h0;
                        state_reg <= ST_HIGH;
                    end
                end
                ST_HIGH: begin
                    cnt_reg <= cnt_reg + 8'h1;
                    if (cnt_reg == STROBE_CYC[7:0]) begin
                        flash_ce_n_o <= 1'b1;
                        flash_dq_oe_o <= 1'b0;
                        if (step_reg == 3'h5) begin
                            done_reg <= 1'b1;
                            if (cmd_reg == `FEC_CMD_SUSPEND) begin
                                suspended_reg <= 1'b1;
                            end else if (cmd_reg == `FEC_CMD_RESUME) begin
                                suspended_reg <= 1'b0;
                            end
                            state_reg <= ST_IDLE;
                        end else begin
                            step_reg <= step_reg + 3'h1;
                            state_reg <= ST_SETUP;
                        end
                    end
                end
                ST_RD: begin
                    flash_addr_o <= target_reg;
                    flash_ce_n_o <= 1'b0;
                    flash_oe_n_o <= 1'b0;
                    flash_we_n_o <= 1'b1;
                    cnt_reg <= cnt_reg + 8'h1;
                    if (cnt_reg == STROBE_CYC[7:0]) begin
                        flash_oe_n_o <= 1'b1;
                        flash_ce_n_o <= 1'b1;
                        cnt_reg <= 8'h0;
                        prev_reg <= flash_dq_i;
                        rdata_reg <= flash_dq_i;
                        state_reg <= ST_RDGAP;
                        if (cmd_reg != `FEC_CMD_POLL || rd_idx_reg == 2'h0) begin
                            rd_idx_reg <= rd_idx_reg + 2'h1;
                            if (cmd_reg != `FEC_CMD_POLL) begin
                                done_reg <= 1'b1;
                                state_reg <= ST_IDLE;
                            end
                        end else if (cur[`FEC_BIT_TOGGLE] == prev_reg[`FEC_BIT_TOGGLE]
                            && cur[`FEC_BIT_POLL]) begin
                            // Toggling stopped and polling bit is 1: erase is over.
                            reread_reg <= reread_reg + 2'h1;
                            if (reread_reg == REREAD_LAST) begin
                                done_reg <= 1'b1;
                                state_reg <= ST_IDLE;
                            end
                        end else if (reread_reg != 2'h0) begin
                            fail_reg <= 1'b1;
                            done_reg <= 1'b1;
                            state_reg <= ST_IDLE;
                        end else begin
                            poll_toggle_reg <= cur[`FEC_BIT_STOGGLE];
                        end
                    end
                end
                ST_RDGAP: begin
                    cnt_reg <= cnt_reg + 8'h1;
                    if (cnt_reg == STROBE_CYC[7:0]) begin
                        cnt_reg <= 8'h0;
                        state_reg <= ST_RD;
                    end
                end
                default: begin
                    flash_ce_n_o <= 1'b1;
                    flash_we_n_o <= 1'b1;
                    flash_oe_n_o <= 1'b1;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** logic/flash_erase_ctrl_defs.vh ***
// Constants for the parallel flash erase controller.
`ifndef FLASH_ERASE_CTRL_DEFS_VH
`define FLASH_ERASE_CTRL_DEFS_VH
`define FEC_OFF_CTRL 12'h000
`define FEC_OFF_ADDR 12'h004
`define FEC_OFF_STATUS 12'h008
`define FEC_OFF_RDATA 12'h00c
`define FEC_CMD_SECTOR 3'h1
`define FEC_CMD_BLOCK 3'h2
`define FEC_CMD_CHIP 3'h3
`define FEC_CMD_SUSPEND 3'h4
`define FEC_CMD_RESUME 3'h5
`define FEC_CMD_READ 3'h6
`define FEC_CMD_POLL 3'h7
`define FEC_CODE_SECTOR 16'h0050
`define FEC_CODE_BLOCK 16'h0030
`define FEC_CODE_CHIP 16'h0010
`define FEC_CODE_SUSPEND 16'h00b0
`define FEC_CODE_RESUME 16'h0030
`define FEC_CODE_UNLOCK1 16'h00aa
`define FEC_CODE_UNLOCK2 16'h0055
`define FEC_CODE_SETUP 16'h0080
`define FEC_ADDR_UNLOCK1 20'h00555
`define FEC_ADDR_UNLOCK2 20'h002aa
`define FEC_STROBE_NS 30
`define FEC_STROBE_CYC ((`FEC_STROBE_NS + 9) / 10)
`define FEC_BIT_POLL 7
`define FEC_BIT_TOGGLE 6
`define FEC_BIT_STOGGLE 2
`define FEC_REREADS 2
`endif

// *** sim/flash_erase_ctrl_assertions.sv ***
// Checker on the flash pins of the erase controller.
`timescale 1ns/1ps
`default_nettype none
module flash_erase_ctrl_assertions #(
    parameter STROBE_CYC = 3
) (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic [19:0] flash_addr_o,
    input wire logic [15:0] flash_dq_o,
    input wire logic flash_dq_oe_o,
    input wire logic flash_ce_n_o,
    input wire logic flash_we_n_o,
    input wire logic flash_oe_n_o,
    input wire logic boot_protect_n_o,
    input wire logic ready_busy_n_i
);
    logic [7:0] lo_cnt;
    always @(posedge mclk_i) begin
        if (!rst_n_i || flash_we_n_o) lo_cnt <= 8'h00;
        else lo_cnt <= lo_cnt + 8'h01;
    end
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    chk_write_select: assert property (
        !flash_we_n_o |-> !flash_ce_n_o && flash_oe_n_o && flash_dq_oe_o)
        else $error("Write strobe without select.");
    chk_read_gate: assert property (
        !flash_oe_n_o |-> !flash_ce_n_o && flash_we_n_o && !flash_dq_oe_o)
        else $error("Read gate during a write.");
    chk_strobe_width: assert property (
        $rose(flash_we_n_o) |-> lo_cnt == STROBE_CYC)
        else $error("Write strobe width wrong.");
    chk_addr_hold: assert property (
        !flash_we_n_o && !$past(flash_we_n_o) |-> $stable(flash_addr_o) && $stable(flash_dq_o))
        else $error("Address or data moved in a strobe.");
    chk_ce_frames_we: assert property (
        $rose(flash_we_n_o) |-> !flash_ce_n_o)
        else $error("Select rose before write strobe.");
    chk_protect_steady: assert property (
        !flash_ce_n_o |-> $stable(boot_protect_n_o))
        else $error("Protect level moved in a cycle.");
    chk_busy_suspend_only: assert property (
        $fell(flash_we_n_o) && !ready_busy_n_i |-> flash_dq_o == 16'h00b0)
        else $error("Command other than suspend while busy.");
    chk_chip_addr: assert property (
        $fell(flash_we_n_o) && flash_dq_o == 16'h0010 |-> flash_addr_o == 20'h00555)
        else $error("Chip erase code at wrong address.");
endmodule
bind flash_erase_ctrl flash_erase_ctrl_assertions #(.STROBE_CYC(STROBE_CYC)) u_chk (
    .mclk_i(mclk_i), .rst_n_i(rst_n_i), .flash_addr_o(flash_addr_o), .flash_dq_o(flash_dq_o),
    .flash_dq_oe_o(flash_dq_oe_o), .flash_ce_n_o(flash_ce_n_o), .flash_we_n_o(flash_we_n_o),
    .flash_oe_n_o(flash_oe_n_o), .boot_protect_n_o(boot_protect_n_o),
    .ready_busy_n_i(ready_busy_n_i));
`default_nettype wire

// *** sim/flash_model.sv ***
// Behavioural x16 NOR flash for erase, suspend and status reads.
`timescale 1ns/1ps
`default_nettype none
module flash_model #(
    parameter int ERASE_CYC = 1500
) (
    input wire logic mclk_i,
    input wire logic [19:0] addr_i,
    input wire logic [15:0] dq_i,
    input wire logic ce_n_i,
    input wire logic we_n_i,
    input wire logic oe_n_i,
    input wire logic boot_protect_n_i,
    output logic [15:0] dq_o,
    output logic ready_busy_n_o
);
    logic [15:0] ud [5] = '{16'h00aa, 16'h0055, 16'h0080, 16'h00aa, 16'h0055};
    logic [19:0] ua [5] = '{20'h00555, 20'h002aa, 20'h00555, 20'h00555, 20'h002aa};
    logic [19:0] la = 0, tgt = 0;
    logic [15:0] last_code = 0, rdv = 0;
    logic busy = 0, susp = 0, tgl = 0, chip = 0;
    int step = 0, n_erase = 0, timer = 0;
    always @(negedge we_n_i) if (!ce_n_i && oe_n_i) la = addr_i;
    always @(posedge we_n_i) if (!ce_n_i && oe_n_i) begin
        if (busy) begin
            if (dq_i == 16'h00b0 && !chip) {busy, susp} = 2'b01;
        end else if (susp) begin
            if (dq_i == 16'h0030) {busy, susp} = 2'b10;
        end else if (step == 5) begin
            step = 0;
            chip = dq_i == 16'h0010 && la == 20'h00555;
            if ((dq_i == 16'h0050 || dq_i == 16'h0030 || chip)
                && (boot_protect_n_i || !chip && la >= 20'h02000)) begin
                busy = 1'b1;
                tgt = la;
                last_code = dq_i;
                timer = ERASE_CYC;
                n_erase++;
            end
        end else if (dq_i == ud[step] && la == ua[step]) step++;
        else step = 0;
    end
    always @(posedge mclk_i) if (busy) begin
        timer--;
        if (timer == 0) busy = 1'b0;
    end
    always @(negedge oe_n_i) if (!ce_n_i) begin
        tgl = ~tgl;
        if (busy) rdv = {9'h000, tgl, 3'b000, tgl, 2'b00};
        else if (susp && addr_i[19:11] == tgt[19:11]) rdv = {8'h00, 2'b11, 3'b000, tgl, 2'b00};
        else if (chip || addr_i[19:11] == tgt[19:11]) rdv = 16'hffff;
        else rdv = addr_i[15:0] ^ 16'h5a5a;
    end
    assign dq_o = !ce_n_i && !oe_n_i ? rdv : ~rdv;
    assign ready_busy_n_o = !busy;
endmodule
`default_nettype wire

// *** sim/tb_flash_erase_ctrl.sv ***
// Self-checking bench for the flash erase controller.
`timescale 1ns/1ps
`default_nettype none
`include "flash_erase_ctrl_defs.vh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_errors++; \
    $display("[ERR] %s expected %h seen %h", nm, e, g); end end
module tb_flash_erase_ctrl;
    logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd;
    logic [19:0] a;
    logic err;
    wire [31:0] prdata;
    wire pready, pslverr, dq_oe, ce_n, we_n, oe_n, wp_n, rb_n;
    wire [19:0] faddr;
    wire [15:0] dq_h, dq_f;
    int n_errors = 0, tests_run = 0, n0;
    initial forever #5 clk = ~clk;
    flash_erase_ctrl dut (.mclk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .flash_addr_o(faddr), .flash_dq_o(dq_h),
        .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_f), .flash_ce_n_o(ce_n), .flash_we_n_o(we_n),
        .flash_oe_n_o(oe_n), .boot_protect_n_o(wp_n), .ready_busy_n_i(rb_n));
    flash_model fm (.mclk_i(clk), .addr_i(faddr), .dq_i(dq_h), .ce_n_i(ce_n), .we_n_i(we_n),
        .oe_n_i(oe_n), .boot_protect_n_i(wp_n), .dq_o(dq_f), .ready_busy_n_o(rb_n));
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] wd);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= wd;
        @(posedge clk) penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic cmd(input logic [2:0] c, input logic [19:0] ad, input logic wp);
        int k;
        apb(1'b1, `FEC_OFF_ADDR, {12'h000, ad});
        apb(1'b1, `FEC_OFF_CTRL, {28'h0, wp, c});
        k = 0;
        do begin
            apb(1'b0, `FEC_OFF_STATUS, 32'h0);
            k++;
        end while (rd[0] !== 1'b0 && k < 3000);
        `CHK("engine_idle", 1'b0, rd[0])
    endtask
    function automatic logic [15:0] code_of(input int c);
        return c == 1 ? 16'h0050 : c == 2 ? 16'h0030 : 16'h0010;
    endfunction
    task automatic stop_test;
        if (n_errors == 0 && tests_run > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        stop_test;
    end
    initial begin
        void'($urandom(90));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, `FEC_OFF_STATUS, 32'h0);
        `CHK("status_reset", 32'h0, rd)
        apb(1'b1, 12'h010, 32'hffffffff);
        apb(1'b0, 12'h010, 32'h0);
        `CHK("unmapped", 32'h0, rd)
        `CHK("unmapped_err", 1'b0, err)
        for (int c = 1; c <= 3; c++) begin
            a = 20'h02000 + 20'($urandom % 32'hfd000);
            n0 = fm.n_erase;
            cmd(3'(c), a, 1'b1);
            `CHK("erase_code", code_of(c), fm.last_code)
            `CHK("erase_addr", c == 3 ? 20'h00555 : a, fm.tgt)
            cmd(3'h7, a, 1'b1);
            `CHK("poll_result", 2'b01, rd[4:3])
            `CHK("erase_count", n0 + 1, fm.n_erase)
            `CHK("ready_after", 1'b1, rb_n)
        end
        for (int c = 1; c <= 3; c++) begin
            n0 = fm.n_erase;
            cmd(3'(c), 20'($urandom % 32'h2000), 1'b0);
            `CHK("protected", n0, fm.n_erase)
        end
        a = 20'h10000 + 20'($urandom % 32'h10000);
        cmd(3'h1, a, 1'b1);
        cmd(3'h4, a, 1'b1);
        `CHK("suspended", 1'b1, rd[2])
        `CHK("ready_susp", 1'b1, rb_n)
        cmd(3'h6, a ^ 20'h80000, 1'b1);
        apb(1'b0, `FEC_OFF_RDATA, 32'h0);
        `CHK("read_outside", a[15:0] ^ 16'h5a5a, rd[15:0])
        cmd(3'h6, a, 1'b1);
        apb(1'b0, `FEC_OFF_RDATA, 32'h0);
        `CHK("read_inside", 2'b11, rd[7:6])
        n0 = 1 - rd[2];
        cmd(3'h6, a, 1'b1);
        apb(1'b0, `FEC_OFF_RDATA, 32'h0);
        `CHK("stoggle", n0, rd[2])
        cmd(3'h5, a ^ 20'h40000, 1'b1);
        `CHK("resumed", 1'b0, rb_n)
        n0 = fm.n_erase;
        cmd(3'h2, a ^ 20'h40000, 1'b1);
        `CHK("busy_refused", n0, fm.n_erase)
        cmd(3'h7, a, 1'b1);
        `CHK("resume_done", 2'b01, rd[4:3])
        stop_test;
    end
endmodule
`default_nettype wire
